/* File: design/fan_cfg_pkg.sv */
package fan_cfg_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADDR_REMOTE_MSB = 8'h36;
   localparam logic [7:0] ADDR_REMOTE_CYC = 8'h37;
   localparam logic [7:0] ADDR_PWM1_CEIL = 8'h38;
   localparam logic [7:0] ADDR_PWM2_CEIL = 8'h39;
   localparam logic [7:0] ADDR_PWM3_CEIL = 8'h3A;
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h40;

   //////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_PWM_CEIL = 8'hFF;
   localparam logic [7:0] RST_MAIN_CFG = 8'h01;
   localparam logic [7:0] RST_REMOTE = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   //////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int REMOTE_MSB_BIT = 0;
   localparam int REMOTE_LOW_HI = 7;
   localparam int REMOTE_LOW_LO = 6;

   // Main configuration layout, bit 7 first
   typedef struct packed {
      logic supplyScale5v;
      logic busTimeoutSelect;
      logic spinupPulseBypass;
      logic corePowerReport;
      logic allFansMax;
      logic ready;
      logic lock;
      logic monitorGo;
   } main_cfg_s;

   //////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CYC_W = 12;
   localparam logic [CYC_W-1:0] DEC_BASE_CYCLES = 12'h008;
   localparam logic [CYC_W-1:0] INC_BASE_CYCLES = 12'h010;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PWRUP_TIME_NS = 10000;
   localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Adjustment pulses of the minimum fan-start temperature loop
   typedef struct packed {
      logic adjustDecrease;
      logic adjustIncrease;
   } temp_step_s;

endpackage

/* File: design/fan_start_temp_interval_timer.sv */
`timescale 1ns/10ps
module fan_start_temp_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] cycleCode,
   input wire logic monitorTick,
   output fan_cfg_pkg::temp_step_s step
);
   logic [fan_cfg_pkg::CYC_W-1:0] decCount_reg, decCount_next;
   logic [fan_cfg_pkg::CYC_W-1:0] incCount_reg, incCount_next;
   logic [fan_cfg_pkg::CYC_W-1:0] decLimit, incLimit;
   fan_cfg_pkg::temp_step_s step_next;
   logic decHit, incHit;

   //////////////////////////////////////////////////////////////////////////////
   // Intervals double per code step, counted in monitoring cycles
   always_comb begin
      decLimit = fan_cfg_pkg::DEC_BASE_CYCLES << cycleCode;
      incLimit = fan_cfg_pkg::INC_BASE_CYCLES << cycleCode;
      // Compare with >= so a shorter code taken mid-interval still fires
      decHit = monitorTick && (decCount_reg >= decLimit - 12'h001);
      incHit = monitorTick && (incCount_reg >= incLimit - 12'h001);
      decCount_next = decCount_reg;
      incCount_next = incCount_reg;
      if (monitorTick) begin
         decCount_next = decHit ? 12'h000 : decCount_reg + 12'h001;
         incCount_next = incHit ? 12'h000 : incCount_reg + 12'h001;
      end
      step_next.adjustDecrease = decHit;
      step_next.adjustIncrease = incHit;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         decCount_reg <= 12'h000;
         incCount_reg <= 12'h000;
         step <= '0;
      end else begin
         decCount_reg <= decCount_next;
         incCount_reg <= incCount_next;
         step <= step_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Checks
   dec_interval_a: assert property (@(posedge clk) disable iff (rst)
      step.adjustDecrease |-> $past(monitorTick)
         && $past(decCount_reg) >= $past(decLimit) - 12'h001)
      else $error("decrease step before its interval");
   inc_interval_a: assert property (@(posedge clk) disable iff (rst)
      (monitorTick && incCount_reg == incLimit - 12'h001) |=> step.adjustIncrease)
      else $error("increase step missing at interval end");
   dec_step_c: cover property (@(posedge clk) disable iff (rst)
      step.adjustDecrease && cycleCode == 3'h1);
endmodule

/* File: design/fan_ctrl_config_lock_bank.sv */
// What this block does
// - Cycle code picks decrease/increase intervals doubling per step, 8/16 up to 1024/2048.
// - Cycle code spaces successive fan-start temperature adjustments in monitoring cycles.
// - Remote code low bits are 0x37 bits 7:6; its top bit lives in 0x36.
// - With lock set, lockable registers become read-only and writes are ignored.
// - Three lockable duty ceiling registers, one per PWM output, reset to 0xFF.
// - Main configuration resets to 0x01: monitoring enabled, other bits clear.
// - Go bit 1 uses programmed limits; 0 uses defaults but keeps programmed values.
// - After locking, the go bit is frozen at its current value.
// - Lock is write-once and holds every lockable register until power cycles.
// - Ready bit reads 1 once power-up has finished.
// - Full-speed bit runs all fans flat out, resets 0, never locks.
// - Core power report flag is a lockable read/write bit.
// - Spin-up bypass holds PWM high for whole timeout instead of two pulses.
// - Bus timeout select is lockable; 1 enables the bus timeout feature.
// - Lockable supply scale bit: 1 measures supply as 5 V, 0 as 3.3 V.
`timescale 1ns/10ps
module fan_ctrl_config_lock_bank #(
   parameter int POWERUP_CYCLES = fan_cfg_pkg::PWRUP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic regRead,
   input wire logic monitorTick,
   output logic [7:0] regRdData,
   output logic regRdValid,
   output logic regWrAck,
   output logic [7:0] pwmLimit [3],
   output fan_cfg_pkg::main_cfg_s cfgOut,
   output fan_cfg_pkg::temp_step_s remoteStep
);
   logic [7:0] pwmCeil_reg [3];
   logic [7:0] pwmCeil_next [3];
   fan_cfg_pkg::main_cfg_s cfg_reg, cfg_next, wrCfg;
   logic [7:0] remoteMsb_reg, remoteMsb_next, remoteCyc_reg, remoteCyc_next;
   logic [7:0] pwmLimit_next [3];
   logic [7:0] rdData_next;
   logic [15:0] pwrCount_reg, pwrCount_next;
   logic ready_reg, ready_next;
   logic locked;
   logic [2:0] remoteCode;

   //////////////////////////////////////////////////////////////////////////////
   // Register writes; lock gates every lockable field
   always_comb begin
      locked = cfg_reg.lock;
      wrCfg = fan_cfg_pkg::main_cfg_s'(regWrData);
      pwmCeil_next = pwmCeil_reg;
      cfg_next = cfg_reg;
      remoteMsb_next = remoteMsb_reg;
      remoteCyc_next = remoteCyc_reg;
      if (regWrite && !locked) begin
         for (int i = 0; i < 3; i++) begin
            if (regAddr == fan_cfg_pkg::ADDR_PWM1_CEIL + 8'(i)) begin
               pwmCeil_next[i] = regWrData;
            end
         end
         if (regAddr == fan_cfg_pkg::ADDR_REMOTE_MSB) begin
            remoteMsb_next = regWrData;
         end
         if (regAddr == fan_cfg_pkg::ADDR_REMOTE_CYC) begin
            remoteCyc_next = regWrData;
         end
      end
      if (regWrite && regAddr == fan_cfg_pkg::ADDR_MAIN_CFG) begin
         // Never-locked fields update in both states
         cfg_next.allFansMax = wrCfg.allFansMax;
         cfg_next.spinupPulseBypass = wrCfg.spinupPulseBypass;
         if (!locked) begin
            cfg_next.monitorGo = wrCfg.monitorGo;
            cfg_next.lock = wrCfg.lock;
            cfg_next.corePowerReport = wrCfg.corePowerReport;
            cfg_next.busTimeoutSelect = wrCfg.busTimeoutSelect;
            cfg_next.supplyScale5v = wrCfg.supplyScale5v;
         end
      end
      cfg_next.ready = 1'b0; // Read side shows the live ready flag instead
   end

   //////////////////////////////////////////////////////////////////////////////
   // Power-up sequencing; lock clears only on reset, so only power loss unlocks
   always_comb begin
      pwrCount_next = pwrCount_reg;
      ready_next = ready_reg;
      if (!ready_reg) begin
         if (pwrCount_reg == 16'(POWERUP_CYCLES - 1)) begin
            ready_next = 1'b1;
         end else begin
            pwrCount_next = pwrCount_reg + 16'h0001;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Read mux and outputs, all registered
   always_comb begin
      unique case (regAddr)
         fan_cfg_pkg::ADDR_REMOTE_MSB: rdData_next = remoteMsb_reg;
         fan_cfg_pkg::ADDR_REMOTE_CYC: rdData_next = remoteCyc_reg;
         fan_cfg_pkg::ADDR_PWM1_CEIL: rdData_next = pwmCeil_reg[0];
         fan_cfg_pkg::ADDR_PWM2_CEIL: rdData_next = pwmCeil_reg[1];
         fan_cfg_pkg::ADDR_PWM3_CEIL: rdData_next = pwmCeil_reg[2];
         fan_cfg_pkg::ADDR_MAIN_CFG: rdData_next = {cfg_reg[7:3], ready_reg, cfg_reg[1:0]};
         default: rdData_next = fan_cfg_pkg::UNMAPPED_READ;
      endcase
   end

   // Per output: defaults while stopped, stored values survive untouched
   for (genvar g = 0; g < 3; g++) begin : g_limit
      always_comb begin
         pwmLimit_next[g] = cfg_reg.monitorGo ? pwmCeil_reg[g] : fan_cfg_pkg::RST_PWM_CEIL;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            pwmCeil_reg[i] <= fan_cfg_pkg::RST_PWM_CEIL;
            pwmLimit[i] <= fan_cfg_pkg::RST_PWM_CEIL;
         end
         cfg_reg <= fan_cfg_pkg::RST_MAIN_CFG;
         cfgOut <= fan_cfg_pkg::RST_MAIN_CFG;
         remoteMsb_reg <= fan_cfg_pkg::RST_REMOTE;
         remoteCyc_reg <= fan_cfg_pkg::RST_REMOTE;
         pwrCount_reg <= 16'h0000;
         ready_reg <= 1'b0;
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
         regWrAck <= 1'b0;
      end else begin
         pwmCeil_reg <= pwmCeil_next;
         pwmLimit <= pwmLimit_next;
         cfg_reg <= cfg_next;
         cfgOut <= {cfg_reg[7:3], ready_reg, cfg_reg[1:0]};
         remoteMsb_reg <= remoteMsb_next;
         remoteCyc_reg <= remoteCyc_next;
         pwrCount_reg <= pwrCount_next;
         ready_reg <= ready_next;
         regRdData <= regRead ? rdData_next : regRdData;
         regRdValid <= regRead;
         regWrAck <= regWrite; // Every write answered, even when dropped
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Remote channel adjustment timer, ticking only while monitoring runs
   always_comb begin
      remoteCode = {remoteMsb_reg[fan_cfg_pkg::REMOTE_MSB_BIT],
                    remoteCyc_reg[fan_cfg_pkg::REMOTE_LOW_HI:fan_cfg_pkg::REMOTE_LOW_LO]};
   end

   fan_start_temp_timer u_remote_timer (
      .clk(clk),
      .rst(rst),
      .cycleCode(remoteCode),
      .monitorTick(monitorTick && cfg_reg.monitorGo),
      .step(remoteStep)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Lock freezes the PWM2 ceiling and remote code bytes, and stays set
   lock_blocks_ceiling_a: assert property (locked && regWrite
      && regAddr == fan_cfg_pkg::ADDR_PWM2_CEIL |=> $stable(pwmCeil_reg[1]))
      else $error("ceiling changed while locked");
   lock_blocks_remote_a: assert property (locked && regWrite
      |=> $stable(remoteMsb_reg) && $stable(remoteCyc_reg))
      else $error("remote code changed while locked");
   lock_sticky_a: assert property (cfg_reg.lock |=> cfg_reg.lock [*8])
      else $error("lock cleared without power cycle");
   // Only a host write may raise the lock
   lock_by_write_a: assert property ($rose(cfg_reg.lock)
      |-> $past(regWrite) && $past(regAddr) == fan_cfg_pkg::ADDR_MAIN_CFG
         && $past(regWrData[1]))
      else $error("lock set without a write");
   go_frozen_a: assert property (locked |=> $stable(cfg_reg.monitorGo))
      else $error("go bit moved after lock");
   // Effective ceilings follow the go bit one cycle later
   stopped_defaults_a: assert property (!cfg_reg.monitorGo
      |=> pwmLimit[0] == 8'hFF && pwmLimit[2] == 8'hFF)
      else $error("defaults not applied while stopped");
   running_limits_a: assert property (cfg_reg.monitorGo
      |=> pwmLimit[1] == $past(pwmCeil_reg[1]))
      else $error("programmed ceiling not applied");
   // Unlocked ceiling writes land and read back
   ceiling_write_a: assert property (!locked && regWrite
      && regAddr == fan_cfg_pkg::ADDR_PWM3_CEIL |=> pwmCeil_reg[2] == $past(regWrData))
      else $error("ceiling write lost");
   ceiling_read_a: assert property (regRead && regAddr == fan_cfg_pkg::ADDR_PWM1_CEIL
      |=> regRdValid && regRdData == $past(pwmCeil_reg[0]))
      else $error("ceiling read wrong");
   // Ready rises once, at the end of the power-up count
   ready_time_a: assert property ($rose(ready_reg)
      |-> $past(pwrCount_reg) == 16'(POWERUP_CYCLES - 1))
      else $error("ready at wrong time");
   ready_sticky_a: assert property (ready_reg |=> ready_reg)
      else $error("ready flag dropped");
   cfg_out_mirror_a: assert property (cfgOut.allFansMax == $past(cfg_reg.allFansMax)
      && cfgOut.ready == $past(ready_reg))
      else $error("config output out of step");
   fans_max_a: assert property (regWrite && regAddr == fan_cfg_pkg::ADDR_MAIN_CFG
      |=> cfg_reg.allFansMax == $past(regWrData[3])
         && cfg_reg.spinupPulseBypass == $past(regWrData[5]))
      else $error("unlocked field lost a write");
   lockable_cfg_a: assert property (locked && regWrite
      |=> $stable(cfg_reg.corePowerReport) && $stable(cfg_reg.busTimeoutSelect)
         && $stable(cfg_reg.supplyScale5v))
      else $error("lockable config bit changed");
   write_ack_a: assert property (regWrite |=> regWrAck ##1 !regWrAck || $past(regWrite))
      else $error("write not acknowledged");

   // Main scenarios

   lock_set_c: cover property ($rose(cfg_reg.lock));
   locked_write_c: cover property (locked && regWrite && regAddr == fan_cfg_pkg::ADDR_PWM3_CEIL);
   ready_c: cover property ($rose(ready_reg));
   stop_go_c: cover property (cfg_reg.monitorGo ##1 !cfg_reg.monitorGo);
endmodule

/* File: tb/bus_host_model.sv */
`timescale 1ns/10ps
module bus_host_model (
   input wire logic clk,
   output logic [7:0] regAddr,
   output logic regWrite,
   output logic [7:0] regWrData,
   output logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic regWrAck,
   output logic hung
);
   // Idle bus at time zero
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regWrData = 8'h00;
      regRead = 1'b0;
      hung = 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////////
   // One byte per access, strobe one cycle, answer one cycle later
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] din,
                       output logic [7:0] dout);
      @(posedge clk);
      #2;
      regAddr = addr;
      regWrData = din;
      regWrite = wr;
      regRead = !wr;
      @(posedge clk);
      #2;
      regWrite = 1'b0;
      regRead = 1'b0;
      // A missing answer is remembered, never waited on
      if ((wr ? regWrAck : regRdValid) !== 1'b1) begin
         hung = 1'b1;
      end
      dout = regRdData;
      // Released lines show the inverse, so stale values cannot pass
      regAddr = ~addr;
      regWrData = ~din;
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic clk;
   logic rst;
   logic monitorTick;
   logic [7:0] regAddr;
   logic regWrite;
   logic [7:0] regWrData;
   logic regRead;
   logic [7:0] regRdData;
   logic regRdValid;
   logic regWrAck;
   logic [7:0] pwmLimit [3];
   fan_cfg_pkg::main_cfg_s cfgOut;
   fan_cfg_pkg::temp_step_s remoteStep;
   logic hung;
   int errors = 0;
   int samples_checked = 0;

   // Short power-up count keeps the run brief
   fan_ctrl_config_lock_bank #(.POWERUP_CYCLES(4)) i_dut (.clk(clk), .rst(rst),
      .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
      .monitorTick(monitorTick), .regRdData(regRdData), .regRdValid(regRdValid),
      .regWrAck(regWrAck), .pwmLimit(pwmLimit), .cfgOut(cfgOut), .remoteStep(remoteStep));

   bus_host_model i_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .regRdValid(regRdValid), .regWrAck(regWrAck), .hung(hung));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      i_host.xfer(1'b1, a, d, x);
      @(posedge clk);
      #2;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] x;
      i_host.xfer(1'b0, a, 8'h00, x);
      chk("read data", {8'h00, x}, {8'h00, exp});
   endtask

   task automatic doReset();
      rst = 1'b1;
      repeat (6) @(posedge clk);
      #2;
      rst = 1'b0;
   endtask

   task automatic tick();
      @(posedge clk);
      #2;
      monitorTick = 1'b1;
      @(posedge clk);
      #2;
      monitorTick = 1'b0;
   endtask

   // Counts ticks up to the first decrease and the first increase pulse
   task automatic timer(input logic [2:0] code);
      int n;
      int decAt;
      decAt = 0;
      n = 0;
      doReset();
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h00);
      wr(fan_cfg_pkg::ADDR_REMOTE_MSB, {7'h00, code[2]});
      wr(fan_cfg_pkg::ADDR_REMOTE_CYC, {code[1:0], 6'h00});
      repeat (3) tick();
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h01);
      while (remoteStep.adjustIncrease !== 1'b1 && n < 2100) begin
         tick();
         n++;
         if (remoteStep.adjustDecrease === 1'b1 && decAt == 0) decAt = n;
      end
      chk("decrease interval", 16'(decAt), 16'(8 << code));
      chk("increase interval", 16'(n), 16'(16 << code));
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      monitorTick = 1'b0;
      doReset();
      rdc(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h01);
      chk("cfgOut", {8'h00, cfgOut}, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         rdc(fan_cfg_pkg::ADDR_PWM1_CEIL + 8'(i), fan_cfg_pkg::RST_PWM_CEIL);
         wr(fan_cfg_pkg::ADDR_PWM1_CEIL + 8'(i), 8'h10 + 8'(i));
         chk("pwmLimit", {8'h00, pwmLimit[i]}, 16'h0010 + 16'(i));
      end
      rdc(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h05);
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h00);
      chk("pwmLimit", {8'h00, pwmLimit[2]}, 16'h00FF);
      rdc(fan_cfg_pkg::ADDR_PWM1_CEIL, 8'h10);
      rdc(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h04);
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'hF9);
      rdc(fan_cfg_pkg::ADDR_MAIN_CFG, 8'hFD);
      chk("cfgOut", {8'h00, cfgOut}, 16'h00FD);
      chk("pwmLimit", {8'h00, pwmLimit[1]}, 16'h0011);
      // Lock, then try to undo everything
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'hFB);
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h00);
      rdc(fan_cfg_pkg::ADDR_MAIN_CFG, 8'hD7);
      wr(fan_cfg_pkg::ADDR_MAIN_CFG, 8'h08);
      chk("cfgOut", {8'h00, cfgOut}, 16'h00DF);
      for (int i = 0; i < 3; i++) begin
         wr(fan_cfg_pkg::ADDR_PWM1_CEIL + 8'(i), 8'h55);
         rdc(fan_cfg_pkg::ADDR_PWM1_CEIL + 8'(i), 8'h10 + 8'(i));
      end
      wr(fan_cfg_pkg::ADDR_REMOTE_CYC, 8'hC0);
      rdc(fan_cfg_pkg::ADDR_REMOTE_CYC, fan_cfg_pkg::RST_REMOTE);
      wr(8'h50, 8'hAA);
      rdc(8'h50, fan_cfg_pkg::UNMAPPED_READ);
      chk("bus answer", {15'h0000, hung}, 16'h0000);
      timer(3'h1);
      timer(3'h3);
      timer(3'h7);
      end_of_test();
   end
endmodule
